// >>> i2c_flags_pkg.sv
// constants and carriers for the flag, clock divider and count block
package i2c_flags_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_CLK_LOW = 8'h0c;
  localparam logic [7:0] OFS_CLK_HIGH = 8'h10;
  localparam logic [7:0] OFS_COUNT = 8'h18;
  localparam logic [7:0] OFS_VECTOR = 8'h28;
  localparam logic [7:0] OFS_INT_COUNT = 8'h2c;
  // status bit positions
  localparam int BIT_AL = 0;
  localparam int BIT_NACK = 1;
  localparam int BIT_REGISTER_ACCESS_READY_FLAG = 2;
  // mode bit positions
  localparam int BIT_RM = 7;
  localparam int BIT_IRS = 5;
  localparam int BIT_MST = 10;
  localparam int BIT_STP = 11;
  // vector codes
  localparam logic [2:0] VEC_NONE = 3'h0;
  localparam logic [2:0] VEC_AL = 3'h1;
  localparam logic [2:0] VEC_NACK = 3'h2;
  localparam logic [2:0] VEC_REGISTER_ACCESS_READY_FLAG = 3'h3;
  // reset values
  localparam logic [15:0] DIV_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [16:0] COUNT_ZERO_LOAD = 17'h10000;
  localparam logic [2:0] PIN_SYNC_RESET = 3'h7;

  // events from the bit engine on the same clock
  typedef struct packed {
    logic regs_taken;
    logic word_done;
    logic tx_word_done;
    logic ack_slot;
    logic ack_is_nack;
    logic transmitter;
    logic general_call;
    logic arb_lost;
    logic start_attempt;
    logic bus_busy_flag;
    logic stop_done;
  } engine_ev_s;

  // flag levels toward the rest of the controller
  typedef struct packed {
    logic register_access_ready_flag;
    logic no_ack_flag;
    logic arbitration_lost_flag;
  } flag_req_s;
endpackage : i2c_flags_pkg

// >>> i2c_master_flags_clock_count.sv
// status flags, serial clock divider and word counter of the bus controller
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - nonrepeat, no stop: ready flag at zero
// - repeat mode: ready flag each sent word
// - ready clears on use, write-1, reset
// - status bits: ready 2, nack 1, lost 0
// - transmitter sets nack on sampled not-acknowledge
// - general call always reports nack as 1
// - nack clears on ack, write-1, vector, reset
// - lost on arbitration loss or busy start
// - lost clears master select and stop request
// - lost clears on write-1, vector read, reset
// - release bit 0 or system reset clears flags
// - clock low time is low divisor plus d
// - clock high time is high divisor plus d
// - serial clock divided down, only as master
// - count copied to counter, decremented per word
// - count zero loads 65536, else value
// - nonrepeat with stop: stop after last word
// - repeat mode: count still loaded into counter, never decremented, no stop
// - upper sixteen bits read zero except internal count bit 16, ignore writes
// - each flag pollable and raises own request
module i2c_master_flags_clock_count #(
  parameter logic [16:0] DIV_OFFSET_D = 17'h00005
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // bit engine events
  input wire i2c_flags_pkg::engine_ev_s engine_ev,
  // control levels toward the bit engine
  output logic master_select,
  output logic stop_request,
  output logic repeat_mode,
  output logic module_running,
  output logic stop_now,
  output logic count_zero,
  // flag requests
  output i2c_flags_pkg::flag_req_s flag_req,
  // serial clock pin, open drain
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n
);

  typedef enum logic [2:0] {
    SCL_IDLE = 3'b001,
    SCL_LOW = 3'b010,
    SCL_HIGH = 3'b100
  } scl_state_e;

  scl_state_e scl_state_q;
  scl_state_e scl_state_d;
  logic [31:0] mode_q;
  logic [15:0] low_div_q;
  logic [15:0] high_div_q;
  logic [15:0] count_reg_q;
  logic [16:0] int_count_q;
  logic register_access_ready_flag_q;
  logic nack_q;
  logic al_q;
  logic [31:0] rdata_q;
  logic [2:0] scl_sync_q;
  logic scl_pin_q;
  logic [16:0] scl_cnt_q;
  logic stop_now_q;
  logic mod_rst;
  logic wr_status;
  logic rd_vector;
  logic [2:0] vec_code;
  logic al_set;
  logic nack_set;
  logic register_access_ready_flag_set;
  logic last_word;
  logic wr_mode;
  logic wr_low;
  logic wr_high;
  logic wr_count;
  logic register_access_ready_flag_clr;
  logic nack_clr;
  logic al_clr;
  logic nack_view;
  logic [31:0] rdata_d;

  // count field to counter start value
  function automatic logic [16:0] count_load(input logic [15:0] v);
    if (v == 16'h0000) begin
      count_load = i2c_flags_pkg::COUNT_ZERO_LOAD;
    end else begin
      count_load = {1'b0, v};
    end
  endfunction : count_load

  // divisor plus offset d
  function automatic logic [16:0] phase_len(input logic [15:0] v);
    phase_len = 17'({1'b0, v} + DIV_OFFSET_D);
  endfunction : phase_len

  // lowest pending flag code
  function automatic logic [2:0] vector_of(input logic al, input logic nk, input logic rd);
    if (al) begin
      vector_of = i2c_flags_pkg::VEC_AL;
    end else if (nk) begin
      vector_of = i2c_flags_pkg::VEC_NACK;
    end else if (rd) begin
      vector_of = i2c_flags_pkg::VEC_REGISTER_ACCESS_READY_FLAG;
    end else begin
      vector_of = i2c_flags_pkg::VEC_NONE;
    end
  endfunction : vector_of

  // decode
  assign mod_rst = reset | ~mode_q[i2c_flags_pkg::BIT_IRS];
  assign wr_status = reg_wr && (reg_addr == i2c_flags_pkg::OFS_STATUS);
  assign wr_mode = reg_wr && (reg_addr == i2c_flags_pkg::OFS_MODE);
  assign wr_low = reg_wr && (reg_addr == i2c_flags_pkg::OFS_CLK_LOW);
  assign wr_high = reg_wr && (reg_addr == i2c_flags_pkg::OFS_CLK_HIGH);
  assign wr_count = reg_wr && (reg_addr == i2c_flags_pkg::OFS_COUNT);
  assign rd_vector = reg_rd && (reg_addr == i2c_flags_pkg::OFS_VECTOR);
  assign vec_code = vector_of(al_q, nack_q, register_access_ready_flag_q);
  assign last_word = engine_ev.word_done && !mode_q[i2c_flags_pkg::BIT_RM]
                     && (int_count_q == 17'h00001);
  assign al_set = engine_ev.arb_lost
                  || (engine_ev.start_attempt && engine_ev.bus_busy_flag);
  assign nack_set = (engine_ev.transmitter && engine_ev.ack_slot && engine_ev.ack_is_nack)
                    || (engine_ev.ack_slot && engine_ev.general_call);
  assign register_access_ready_flag_set = mode_q[i2c_flags_pkg::BIT_MST]
                    && ((last_word && !mode_q[i2c_flags_pkg::BIT_STP])
                    || (mode_q[i2c_flags_pkg::BIT_RM] && engine_ev.tx_word_done));
  // flag clear conditions
  assign register_access_ready_flag_clr = engine_ev.regs_taken
                    || (wr_status && reg_wdata[i2c_flags_pkg::BIT_REGISTER_ACCESS_READY_FLAG]);
  assign nack_clr = (engine_ev.ack_slot && !engine_ev.ack_is_nack)
                    || (wr_status && reg_wdata[i2c_flags_pkg::BIT_NACK])
                    || (rd_vector && vec_code == i2c_flags_pkg::VEC_NACK);
  assign al_clr = (wr_status && reg_wdata[i2c_flags_pkg::BIT_AL])
                  || (rd_vector && vec_code == i2c_flags_pkg::VEC_AL);
  // general call forces the reported no-ack high
  assign nack_view = nack_q | engine_ev.general_call;

  // mode register; the release bit survives its own reset
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode_q <= 32'h00000000;
    end else begin
      if (!mode_q[i2c_flags_pkg::BIT_IRS]) begin
        mode_q[i2c_flags_pkg::BIT_MST] <= 1'b0;
        mode_q[i2c_flags_pkg::BIT_STP] <= 1'b0;
      end
      if (wr_mode) begin
        mode_q <= {16'h0000, reg_wdata[15:0]};
        // master and stop only take hold together with the release bit
        if (!reg_wdata[i2c_flags_pkg::BIT_IRS]) begin
          mode_q[i2c_flags_pkg::BIT_MST] <= 1'b0;
          mode_q[i2c_flags_pkg::BIT_STP] <= 1'b0;
        end
      end
      if (al_set || engine_ev.stop_done) begin
        mode_q[i2c_flags_pkg::BIT_MST] <= 1'b0;
        mode_q[i2c_flags_pkg::BIT_STP] <= 1'b0;
      end
    end
  end

  // divisor and count registers, writable at any time
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      low_div_q <= i2c_flags_pkg::DIV_RESET;
      high_div_q <= i2c_flags_pkg::DIV_RESET;
      count_reg_q <= i2c_flags_pkg::COUNT_RESET;
    end else begin
      if (wr_low) begin
        low_div_q <= reg_wdata[15:0];
      end
      if (wr_high) begin
        high_div_q <= reg_wdata[15:0];
      end
      if (wr_count) begin
        count_reg_q <= reg_wdata[15:0];
      end
    end
  end

  // internal word counter
  always_ff @(posedge ref_clk) begin
    if (mod_rst) begin
      int_count_q <= i2c_flags_pkg::COUNT_ZERO_LOAD;
    end else if (wr_count) begin
      int_count_q <= count_load(reg_wdata[15:0]);
    end else if (engine_ev.regs_taken) begin
      int_count_q <= count_load(count_reg_q);
    end else if (engine_ev.word_done && !mode_q[i2c_flags_pkg::BIT_RM]
                 && int_count_q != 17'h00000) begin
      int_count_q <= int_count_q - 17'h00001;
    end
  end

  // stop request at end of count
  always_ff @(posedge ref_clk) begin
    if (mod_rst) begin
      stop_now_q <= 1'b0;
    end else begin
      stop_now_q <= last_word && mode_q[i2c_flags_pkg::BIT_STP];
    end
  end

  // register-access-ready flag, set wins over clear
  always_ff @(posedge ref_clk) begin
    if (mod_rst) begin
      register_access_ready_flag_q <= 1'b0;
    end else if (register_access_ready_flag_set) begin
      register_access_ready_flag_q <= 1'b1;
    end else if (register_access_ready_flag_clr) begin
      register_access_ready_flag_q <= 1'b0;
    end
  end

  // no-acknowledge flag
  always_ff @(posedge ref_clk) begin
    if (mod_rst) begin
      nack_q <= 1'b0;
    end else if (nack_set) begin
      nack_q <= 1'b1;
    end else if (nack_clr) begin
      nack_q <= 1'b0;
    end
  end

  // arbitration-lost flag
  always_ff @(posedge ref_clk) begin
    if (mod_rst) begin
      al_q <= 1'b0;
    end else if (al_set) begin
      al_q <= 1'b1;
    end else if (al_clr) begin
      al_q <= 1'b0;
    end
  end

  // serial clock pin synchroniser
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scl_sync_q <= i2c_flags_pkg::PIN_SYNC_RESET;
      scl_pin_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], scl_in};
      // a change counts once stages two and three agree
      if (scl_sync_q[1] == scl_sync_q[2]) begin
        scl_pin_q <= scl_sync_q[2];
      end
    end
  end

  // clock phase machine
  always_comb begin
    scl_state_d = scl_state_q;
    case (scl_state_q)
      SCL_IDLE: begin
        if (mode_q[i2c_flags_pkg::BIT_MST]) begin
          scl_state_d = SCL_LOW;
        end
      end
      SCL_LOW: begin
        if (!mode_q[i2c_flags_pkg::BIT_MST]) begin
          scl_state_d = SCL_IDLE;
        end else if (scl_cnt_q <= 17'h00001) begin
          scl_state_d = SCL_HIGH;
        end
      end
      SCL_HIGH: begin
        if (!mode_q[i2c_flags_pkg::BIT_MST]) begin
          scl_state_d = SCL_IDLE;
        end else if (scl_cnt_q <= 17'h00001 && scl_pin_q) begin
          scl_state_d = SCL_LOW;
        end
      end
      default: begin
        scl_state_d = SCL_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (mod_rst) begin
      scl_state_q <= SCL_IDLE;
    end else begin
      scl_state_q <= scl_state_d;
    end
  end

  // phase length counter; high phase waits for the line to rise
  always_ff @(posedge ref_clk) begin
    if (mod_rst) begin
      scl_cnt_q <= 17'h00000;
    end else if (scl_state_d != scl_state_q) begin
      if (scl_state_d == SCL_LOW) begin
        scl_cnt_q <= phase_len(low_div_q);
      end else begin
        scl_cnt_q <= phase_len(high_div_q);
      end
    end else if (scl_cnt_q > 17'h00001 && (scl_state_q != SCL_HIGH || scl_pin_q)) begin
      scl_cnt_q <= scl_cnt_q - 17'h00001;
    end
  end

  // read mux; the strobe's address picks the word shown next cycle
  always_comb begin
    rdata_d = 32'h00000000;
    if (reg_rd) begin
      case (reg_addr)
        i2c_flags_pkg::OFS_MODE: begin
          rdata_d = mode_q;
        end
        i2c_flags_pkg::OFS_STATUS: begin
          rdata_d = {29'h00000000, register_access_ready_flag_q, nack_view, al_q};
        end
        i2c_flags_pkg::OFS_CLK_LOW: begin
          rdata_d = {16'h0000, low_div_q};
        end
        i2c_flags_pkg::OFS_CLK_HIGH: begin
          rdata_d = {16'h0000, high_div_q};
        end
        i2c_flags_pkg::OFS_COUNT: begin
          rdata_d = {16'h0000, count_reg_q};
        end
        i2c_flags_pkg::OFS_VECTOR: begin
          rdata_d = {29'h00000000, vec_code};
        end
        i2c_flags_pkg::OFS_INT_COUNT: begin
          rdata_d = {15'h0000, int_count_q};
        end
        default: begin
          rdata_d = 32'h00000000;
        end
      endcase
    end
  end

  // read data register, zero outside the answer cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // outputs
  assign reg_rdata = rdata_q;
  assign master_select = mode_q[i2c_flags_pkg::BIT_MST];
  assign stop_request = mode_q[i2c_flags_pkg::BIT_STP];
  assign repeat_mode = mode_q[i2c_flags_pkg::BIT_RM];
  assign module_running = mode_q[i2c_flags_pkg::BIT_IRS];
  assign stop_now = stop_now_q;
  assign count_zero = (int_count_q == 17'h00000);
  assign flag_req = {register_access_ready_flag_q,
                     nack_view,
                     al_q};
  assign scl_out = 1'b0;
  assign scl_oe_n = (scl_state_q != SCL_LOW);

endmodule : i2c_master_flags_clock_count
`default_nettype wire

// >>> i2c_master_flags_clock_count_chk.sv
// port checker for the flag, clock divider and count block
`timescale 1ns/1ps
`default_nettype none
module i2c_flags_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // observed ports
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire i2c_flags_pkg::engine_ev_s engine_ev,
  input wire logic master_select,
  input wire logic stop_request,
  input wire logic repeat_mode,
  input wire logic module_running,
  input wire logic stop_now,
  input wire i2c_flags_pkg::flag_req_s flag_req,
  input wire logic scl_oe_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_nack_seen;
    engine_ev.ack_slot && engine_ev.ack_is_nack && engine_ev.transmitter && module_running;
  endsequence
  sequence s_lost;
    (engine_ev.arb_lost || (engine_ev.start_attempt && engine_ev.bus_busy_flag)) && module_running;
  endsequence
  chk_rd_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside read answer");
  chk_nack_set: assert property (s_nack_seen |=> flag_req.no_ack_flag)
    else $error("no-ack flag not set");
  chk_lost_set: assert property (s_lost |=> flag_req.arbitration_lost_flag)
    else $error("lost flag not set");
  chk_lost_mode: assert property (s_lost |=> !master_select && !stop_request)
    else $error("master or stop kept after loss");
  chk_gcall_nack: assert property (engine_ev.general_call && module_running
    |-> flag_req.no_ack_flag)
    else $error("no-ack low in general call");
  chk_stop_once: assert property (stop_now |=> !stop_now)
    else $error("stop pulse too long");
  chk_stop_cause: assert property (stop_now
    |-> $past(engine_ev.word_done && stop_request && !repeat_mode))
    else $error("stop without counted word");
  chk_taken_clear: assert property (engine_ev.regs_taken && !engine_ev.word_done
    && !engine_ev.tx_word_done && module_running |=> !flag_req.register_access_ready_flag)
    else $error("ready flag kept after use");
  chk_held_flags: assert property (!module_running [*2]
    |-> !flag_req.register_access_ready_flag && !flag_req.arbitration_lost_flag)
    else $error("flag set in module reset");
  chk_slave_quiet: assert property (!master_select [*3] |-> scl_oe_n)
    else $error("clock driven as slave");
endmodule : i2c_flags_chk
bind i2c_master_flags_clock_count i2c_flags_chk chk_i (.ref_clk(ref_clk), .reset(reset),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .engine_ev(engine_ev),
  .master_select(master_select), .stop_request(stop_request), .repeat_mode(repeat_mode),
  .module_running(module_running), .stop_now(stop_now), .flag_req(flag_req),
  .scl_oe_n(scl_oe_n));
`default_nettype wire

// >>> i2c_bus_peer.sv
// serial clock line with pull-up and a peer that can stretch the low phase
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_peer (
  // clock
  input wire logic ref_clk,
  // line
  input wire logic scl_oe_n,
  input wire logic [3:0] stretch,
  output logic scl_in
);
  logic [3:0] hold_q = 4'h0;
  always_ff @(posedge ref_clk) begin
    if (!scl_oe_n) begin
      hold_q <= stretch;
    end else if (hold_q != 4'h0) begin
      hold_q <= hold_q - 4'h1;
    end
  end
  // wired-and, pulled up once nobody holds it
  assign scl_in = scl_oe_n && (hold_q == 4'h0);
endmodule : i2c_bus_peer
`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the flag, clock divider and count block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [7:0] ST = i2c_flags_pkg::OFS_STATUS;
  localparam logic [7:0] IC = i2c_flags_pkg::OFS_INT_COUNT;
  localparam logic [7:0] MD = i2c_flags_pkg::OFS_MODE;
  localparam logic [7:0] VC = i2c_flags_pkg::OFS_VECTOR;
  localparam logic [7:0] CN = i2c_flags_pkg::OFS_COUNT;
  localparam int DIV_D = 3;
  // pin sense delay: three sync stages and the held level
  localparam int SENSE = 4;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  i2c_flags_pkg::engine_ev_s engine_ev = '0;
  i2c_flags_pkg::flag_req_s flag_req;
  logic master_select, stop_request, repeat_mode, module_running, stop_now, count_zero;
  logic scl_in, scl_out, scl_oe_n;
  logic [3:0] stretch = 4'h0;
  int fails = 0;
  int check_count = 0;
  int n;
  always #25 ref_clk = ~ref_clk;
  i2c_master_flags_clock_count #(.DIV_OFFSET_D(17'h00003)) dut (.ref_clk(ref_clk),
    .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .engine_ev(engine_ev),
    .master_select(master_select), .stop_request(stop_request), .repeat_mode(repeat_mode),
    .module_running(module_running), .stop_now(stop_now), .count_zero(count_zero),
    .flag_req(flag_req),
    .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n));
  i2c_bus_peer peer (.ref_clk(ref_clk), .scl_oe_n(scl_oe_n), .stretch(stretch), .scl_in(scl_in));
  task automatic results;
    if (fails == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  task automatic eq(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : eq
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    eq(reg_rdata, e);
  endtask : rd
  task automatic ev(input logic [10:0] e);
    @(posedge ref_clk);
    engine_ev <= e;
    @(posedge ref_clk);
    engine_ev <= '0;
    #1;
  endtask : ev
  task automatic phase(input logic lvl);
    n = 0;
    while (scl_oe_n === lvl && n < 300) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask : phase
  task automatic t_regs;
    rd(ST, 32'h0);
    rd(IC, 32'h10000);
    wr(i2c_flags_pkg::OFS_CLK_LOW, 32'hffff_0003);
    wr(i2c_flags_pkg::OFS_CLK_HIGH, 32'h0000_0004);
    rd(i2c_flags_pkg::OFS_CLK_LOW, 32'h3);
    rd(8'h3c, 32'h0);
  endtask : t_regs
  task automatic t_scl;
    wr(MD, 32'h420);
    phase(1'b1);
    phase(1'b0);
    eq(32'(n), 32'(3 + DIV_D));
    eq(scl_out, 1'b0);
    phase(1'b1);
    eq(32'(n), 32'(4 + DIV_D + SENSE));
    stretch <= 4'h5;
    phase(1'b0);
    phase(1'b1);
    eq(32'(n), 32'(4 + DIV_D + SENSE + 5));
    stretch <= 4'h0;
    wr(MD, 32'h0);
  endtask : t_scl
  task automatic t_count;
    wr(MD, 32'h420);
    wr(CN, 32'h0);
    rd(IC, 32'h10000);
    wr(CN, 32'h2);
    ev(11'h200);
    rd(IC, 32'h1);
    rd(CN, 32'h2);
    ev(11'h200);
    eq(count_zero, 1'b1);
    rd(ST, 32'h4);
    ev(11'h400);
    rd(ST, 32'h0);
    rd(IC, 32'h2);
    wr(MD, 32'hc20);
    wr(CN, 32'h1);
    ev(11'h200);
    eq(stop_now, 1'b1);
    eq(flag_req.register_access_ready_flag, 1'b0);
    ev(11'h001);
    eq(master_select, 1'b0);
  endtask : t_count
  task automatic t_repeat;
    wr(MD, 32'h4a0);
    wr(CN, 32'h3);
    ev(11'h200);
    rd(IC, 32'h3);
    eq(repeat_mode, 1'b1);
    ev(11'h100);
    rd(ST, 32'h4);
    wr(ST, 32'h4);
    rd(ST, 32'h0);
  endtask : t_repeat
  task automatic t_nack;
    ev(11'h0e0);
    eq(32'(flag_req), 32'h2);
    rd(ST, 32'h2);
    rd(VC, 32'h2);
    rd(ST, 32'h0);
    ev(11'h0e0);
    ev(11'h0a0);
    rd(ST, 32'h0);
    ev(11'h0b0);
    rd(ST, 32'h2);
    wr(ST, 32'h2);
    rd(ST, 32'h0);
  endtask : t_nack
  task automatic t_lost;
    wr(MD, 32'hc20);
    ev(11'h008);
    rd(ST, 32'h1);
    rd(MD, 32'h20);
    rd(VC, 32'h1);
    rd(ST, 32'h0);
    ev(11'h006);
    rd(ST, 32'h1);
    wr(ST, 32'h1);
    rd(ST, 32'h0);
    ev(11'h008);
    wr(MD, 32'h0);
    rd(ST, 32'h0);
    eq(module_running, 1'b0);
    ev(11'h008);
    rd(ST, 32'h0);
    rd(i2c_flags_pkg::OFS_CLK_LOW, 32'h3);
  endtask : t_lost
  initial begin
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    t_regs();
    t_scl();
    t_count();
    t_repeat();
    t_nack();
    t_lost();
    results();
  end
  initial begin
    #1000000;
    fails++;
    results();
  end
endmodule : tb_top
`default_nettype wire
